// ### logic/iuv_pkg.sv
// Constants and types for the input undervoltage fault handler
package iuv_pkg;
  // Command codes of the two registers
  localparam logic [7:0]  CmdTripLevel   = 8'h59;
  localparam logic [7:0]  CmdReaction    = 8'h5a;
  // Field positions in the reaction register
  localparam int          RespHi         = 7;
  localparam int          RespLo         = 6;
  localparam int          RetryHi        = 5;
  localparam int          RetryLo        = 3;
  localparam int          DelayHi        = 2;
  localparam int          DelayLo        = 0;
  // Values after reset
  localparam logic [15:0] TripLevelReset = 16'h0000;
  localparam logic [7:0]  ReactionReset  = 8'h00;
  // Response codes
  localparam logic [1:0]  RespIgnore     = 2'h0;
  localparam logic [1:0]  RespDelayed    = 2'h1;
  localparam logic [1:0]  RespRetry      = 2'h2;
  localparam logic [1:0]  RespLatch      = 2'h3;
  // Retry settings with special meaning
  localparam logic [2:0]  RetryNone      = 3'h0;
  localparam logic [2:0]  RetryForever   = 3'h7;

  typedef enum logic [2:0] {
    StRun,
    StDelay,
    StWait,
    StTry,
    StOff
  } iuv_state_type;
endpackage

// ### logic/iuv_fault_handler.sv
// Input undervoltage fault handler with trip level and reaction registers
`timescale 1ns/100ps

// Contract
// - Sixteen-bit trip level register; input below it means undervoltage.
// - Reaction code 00 ignores the fault and keeps the output running.
// - Code 01 keeps running for the delay, then acts on retry setting.
// - Code 10 disables the output at once, then follows the retry setting.
// - Code 11 disables the output and holds it off until cleared.
// - Status clear, clear-all, reset or off-then-on clears a latched fault.
// - Retry setting 000 makes no restart; output stays off until cleared.
// - Settings 1 to 6 restart that often, then stay off until cleared.
// - Restart attempt starts are spaced by the delay times the unit.
// - Setting 111 retries forever until commanded off or another fault.
// - Delay field n selects two to the power n delay units.
// - One delay count serves continued running or restart spacing.
// - Duration of one delay unit comes from a separate configuration value.
module iuv_fault_handler (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmdWrite,
  input  wire logic        cmdRead,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] cmdData,
  output logic      [15:0] readData,
  output logic             readValid,
  input  wire logic        clearFaults,
  input  wire logic        clearUvStatus,
  input  wire logic        runEnable,
  input  wire logic        otherFaultOff,
  input  wire logic [15:0] unitCycles,
  input  wire logic        vinValid,
  input  wire logic [15:0] vinLevel,
  output logic             outputEnable,
  output logic             uvFault,
  output logic             uvStatus
);

  logic [15:0]            tripLevel_q;
  logic [7:0]             reaction_q;
  logic [15:0]            readData_q;
  logic                   readValid_q;
  logic                   uvFault_q;
  logic                   uvStatus_q;
  logic                   outEn_q;
  logic                   runPrev_q;
  logic [15:0]            tickCnt_q;
  logic [7:0]             unitCnt_q;
  logic                   dlyExp_q;
  logic [2:0]             left_q;
  iuv_pkg::iuv_state_type state_q;
  iuv_pkg::iuv_state_type state_d;
  logic                   startDly;
  logic                   loadLeft;
  logic                   decLeft;

  // Register decode, shared by writes and reads
  wire        hitTrip  = cmdCode == iuv_pkg::CmdTripLevel;
  wire        hitReact = cmdCode == iuv_pkg::CmdReaction;
  wire        wrTrip   = cmdWrite & hitTrip;
  wire        wrReact  = cmdWrite & hitReact;
  wire [15:0] rdMux    = hitTrip  ? tripLevel_q :
                         hitReact ? {8'h00, reaction_q} : 16'h0000;

  wire [1:0] respMode = reaction_q[iuv_pkg::RespHi:iuv_pkg::RespLo];
  wire [2:0] retrySet = reaction_q[iuv_pkg::RetryHi:iuv_pkg::RetryLo];
  wire [2:0] delaySel = reaction_q[iuv_pkg::DelayHi:iuv_pkg::DelayLo];

  wire below     = vinValid & (vinLevel < tripLevel_q);
  wire above     = vinValid & ~(vinLevel < tripLevel_q);
  wire onRise    = runEnable & ~runPrev_q;
  wire clearAll  = clearFaults | clearUvStatus | onRise;
  wire forceRun  = clearAll | ~runEnable;
  wire abort     = forceRun | otherFaultOff;
  wire endless   = retrySet == iuv_pkg::RetryForever;

  // Delay timer: unit length from the outside configuration register
  wire       dlyRun    = (state_q == iuv_pkg::StDelay) |
                         (state_q == iuv_pkg::StWait) |
                         (state_q == iuv_pkg::StTry);
  wire       unitTick  = (tickCnt_q + 16'h0001) >= unitCycles;
  wire [7:0] unitsNeed = 8'h01 << delaySel;
  wire       lastUnit  = (unitCnt_q + 8'h01) == unitsNeed;
  wire       dlyDone   = dlyRun & ~dlyExp_q & unitTick & lastUnit;
  wire       dlyOver   = dlyDone | dlyExp_q;
  wire       outOn     = runEnable & ~otherFaultOff &
                         ((state_d == iuv_pkg::StRun) |
                          (state_d == iuv_pkg::StDelay) |
                          (state_d == iuv_pkg::StTry));

  // Shutdown target shared by immediate and delayed responses
  wire                    offTarget = retrySet == iuv_pkg::RetryNone;

  always_ff @(posedge clk) begin
    if (rst) begin
      tripLevel_q <= iuv_pkg::TripLevelReset;
    end else if (wrTrip) begin
      tripLevel_q <= cmdData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reaction_q <= iuv_pkg::ReactionReset;
    end else if (wrReact) begin
      reaction_q <= cmdData[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readData_q  <= 16'h0000;
      readValid_q <= 1'b0;
    end else begin
      readValid_q <= cmdRead;
      if (cmdRead) begin
        readData_q <= rdMux;
      end
    end
  end

  // Fault condition follows each measurement
  always_ff @(posedge clk) begin
    if (rst) begin
      uvFault_q <= 1'b0;
    end else if (vinValid) begin
      uvFault_q <= below;
    end
  end

  // A new detection in the clearing cycle wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      uvStatus_q <= 1'b0;
    end else if (below) begin
      uvStatus_q <= 1'b1;
    end else if (clearAll) begin
      uvStatus_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      runPrev_q <= 1'b0;
      outEn_q   <= 1'b0;
    end else begin
      runPrev_q <= runEnable;
      outEn_q   <= outOn;
    end
  end

  // Timer halts once expired so a late measurement still sees the end
  always_ff @(posedge clk) begin
    if (rst || startDly) begin
      tickCnt_q <= 16'h0000;
      unitCnt_q <= 8'h00;
      dlyExp_q  <= 1'b0;
    end else if (dlyRun && !dlyExp_q) begin
      dlyExp_q <= dlyDone;
      if (unitTick) begin
        tickCnt_q <= 16'h0000;
        unitCnt_q <= unitCnt_q + 8'h01;
      end else begin
        tickCnt_q <= tickCnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      left_q <= 3'h0;
    end else if (loadLeft) begin
      left_q <= retrySet;
    end else if (decLeft) begin
      left_q <= left_q - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= iuv_pkg::StRun;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    state_d  = state_q;
    startDly = 1'b0;
    loadLeft = 1'b0;
    decLeft  = 1'b0;
    if (forceRun) begin
      state_d = iuv_pkg::StRun;
    end else if (otherFaultOff) begin
      state_d = iuv_pkg::StOff;
    end else begin
      unique case (state_q)
        iuv_pkg::StRun: begin
          if (below) begin
            loadLeft = 1'b1;
            unique case (respMode)
              iuv_pkg::RespIgnore: begin
                state_d = iuv_pkg::StRun;
              end
              iuv_pkg::RespDelayed: begin
                state_d  = iuv_pkg::StDelay;
                startDly = 1'b1;
              end
              iuv_pkg::RespRetry: begin
                state_d  = offTarget ? iuv_pkg::StOff
                                     : iuv_pkg::StWait;
                startDly = ~offTarget;
              end
              iuv_pkg::RespLatch: begin
                state_d = iuv_pkg::StOff;
              end
            endcase
          end
        end
        iuv_pkg::StDelay: begin
          if (dlyOver) begin
            if (uvFault_q) begin
              state_d  = offTarget ? iuv_pkg::StOff
                                   : iuv_pkg::StWait;
              startDly = ~offTarget;
            end else begin
              state_d = iuv_pkg::StRun;
            end
          end
        end
        iuv_pkg::StWait: begin
          if (dlyOver) begin
            // Next attempt starts one delay after the last one, or right after the wait begins if the last one outlasted the delay
            state_d  = iuv_pkg::StTry;
            startDly = 1'b1;
          end
        end
        iuv_pkg::StTry: begin
          if (below) begin
            decLeft = ~endless;
            state_d = (!endless && left_q == 3'h1) ? iuv_pkg::StOff
                                                    : iuv_pkg::StWait;
          end else if (above) begin
            state_d = iuv_pkg::StRun;
          end
        end
        iuv_pkg::StOff: begin
          state_d = iuv_pkg::StOff;
        end
      endcase
    end
  end

  assign readData     = readData_q;
  assign readValid    = readValid_q;
  assign outputEnable = outEn_q;
  assign uvFault      = uvFault_q;
  assign uvStatus     = uvStatus_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  trip_write_a: assert property (
    wrTrip |=> tripLevel_q == $past(cmdData))
    else $error("trip level not written");

  ignore_runs_a: assert property (
    state_q == iuv_pkg::StRun && respMode == iuv_pkg::RespIgnore &&
    below && !abort |=> state_q == iuv_pkg::StRun && outEn_q)
    else $error("ignored fault stopped output");

  delay_keeps_a: assert property (
    state_q == iuv_pkg::StRun && respMode == iuv_pkg::RespDelayed &&
    below && !abort |=> state_q == iuv_pkg::StDelay && outEn_q)
    else $error("delayed response stopped output");

  retry_off_a: assert property (
    state_q == iuv_pkg::StRun && respMode == iuv_pkg::RespRetry &&
    below && !abort |=> !outEn_q)
    else $error("output not disabled at once");

  latch_off_a: assert property (
    state_q == iuv_pkg::StOff && !abort |=>
    state_q == iuv_pkg::StOff && !outEn_q)
    else $error("latched off state left");

  clear_status_a: assert property (
    clearAll && !below |=> !uvStatus_q)
    else $error("fault status not cleared");

  no_retry_a: assert property (
    state_q == iuv_pkg::StRun && respMode == iuv_pkg::RespRetry &&
    retrySet == iuv_pkg::RetryNone && below && !abort |=>
    state_q == iuv_pkg::StOff)
    else $error("restart despite zero retries");

  retry_count_a: assert property (
    state_q == iuv_pkg::StTry && below && !endless &&
    left_q == 3'h1 && !abort |=> state_q == iuv_pkg::StOff)
    else $error("retries not exhausted to off");

  forever_a: assert property (
    state_q == iuv_pkg::StTry && below && endless && !abort |=>
    state_q == iuv_pkg::StWait && $stable(left_q))
    else $error("continuous retry stopped");

  delay_span_a: assert property (
    startDly && delaySel == 3'h1 && unitCycles == 16'h0002 &&
    !wrReact |=> !dlyDone [*3] ##1 (dlyDone || !dlyRun))
    else $error("delay span wrong");

endmodule

// ### sim/iuv_host_model.sv
// Host model that writes registers, reads them back and clears faults
`timescale 1ns/100ps
module iuv_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] readData,
  input  wire logic        readValid,
  output logic             cmdWrite,
  output logic             cmdRead,
  output logic      [7:0]  cmdCode,
  output logic      [15:0] cmdData,
  output logic             clearFaults,
  output logic             clearUvStatus
);
  initial begin
    cmdWrite = 1'h0;
    cmdRead = 1'h0;
    cmdCode = 8'h00;
    cmdData = 16'h0000;
    clearFaults = 1'h0;
    clearUvStatus = 1'h0;
  end

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmdWrite <= 1'h1;
    cmdCode <= code;
    cmdData <= data;
    @(posedge clk);
    cmdWrite <= 1'h0;
    // Idle bus shows no stale value
    cmdCode <= ~code;
    cmdData <= ~data;
  endtask

  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    int n;
    @(posedge clk);
    cmdRead <= 1'h1;
    cmdCode <= code;
    @(posedge clk);
    cmdRead <= 1'h0;
    cmdCode <= ~code;
    #1;
    n = 0;
    while (readValid !== 1'h1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    data = readData;
  endtask

  task automatic clear(input logic all);
    @(posedge clk);
    clearFaults <= all;
    clearUvStatus <= ~all;
    @(posedge clk);
    clearFaults <= 1'h0;
    clearUvStatus <= 1'h0;
  endtask
endmodule

// ### sim/iuv_fault_handler_tb.sv
// Self-checking bench for the undervoltage fault handler
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module iuv_fault_handler_tb;
  logic clk = 1'h0, rst = 1'h1, runEnable = 1'h1, otherFaultOff = 1'h0;
  logic vinValid = 1'h0, cmdWrite, cmdRead, clearFaults, clearUvStatus;
  logic [15:0] unitCycles = 16'h0001, vinLevel = 16'h0000, cmdData;
  logic [15:0] readData, d;
  logic [7:0]  cmdCode;
  logic        readValid, outputEnable, uvFault, uvStatus;
  int          checks = 0, miscompares = 0, cyc = 0, n;
  localparam logic [15:0] Lo = 16'h0fff;
  localparam logic [15:0] Hi = 16'h2000;

  always #50 clk = ~clk;

  iuv_host_model host_u (.clk(clk), .readData(readData),
    .readValid(readValid), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdCode(cmdCode), .cmdData(cmdData), .clearFaults(clearFaults),
    .clearUvStatus(clearUvStatus));

  iuv_fault_handler dut_u (.clk(clk), .rst(rst), .cmdWrite(cmdWrite),
    .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdData(cmdData),
    .readData(readData), .readValid(readValid), .clearFaults(clearFaults),
    .clearUvStatus(clearUvStatus), .runEnable(runEnable),
    .otherFaultOff(otherFaultOff), .unitCycles(unitCycles),
    .vinValid(vinValid), .vinLevel(vinLevel), .outputEnable(outputEnable),
    .uvFault(uvFault), .uvStatus(uvStatus));

  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report;
    end
  end

  task automatic smp(input logic [15:0] v);
    @(posedge clk);
    vinValid <= 1'h1;
    vinLevel <= v;
    @(posedge clk);
    vinValid <= 1'h0;
    vinLevel <= ~v;
  endtask

  // Bounded wait so a stuck output shows up as a miscompare, not a hang
  task automatic waitOe(input logic v, output int k);
    k = 0;
    #1;
    while (outputEnable !== v && k < 600) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  task automatic t_regs;
    host_u.rd(iuv_pkg::CmdTripLevel, d);
    `CHK(d, iuv_pkg::TripLevelReset)
    `CHK(readValid, 1'h1)
    @(posedge clk);
    #1;
    `CHK(readValid, 1'h0)
    host_u.rd(iuv_pkg::CmdReaction, d);
    `CHK(d, {8'h00, iuv_pkg::ReactionReset})
    host_u.wr(iuv_pkg::CmdTripLevel, 16'hffff);
    host_u.rd(iuv_pkg::CmdTripLevel, d);
    `CHK(d, 16'hffff)
    host_u.wr(iuv_pkg::CmdTripLevel, 16'h1000);
    host_u.wr(iuv_pkg::CmdReaction, 16'hab00);
    host_u.rd(iuv_pkg::CmdReaction, d);
    `CHK(d, 16'h0000)
    host_u.rd(8'h5b, d);
    `CHK(d, 16'h0000)
    $display("register test done");
  endtask

  task automatic t_ignore;
    smp(16'h1000);
    repeat (3) @(posedge clk);
    `CHK(uvFault, 1'h0)
    smp(Lo);
    repeat (10) @(posedge clk);
    `CHK({uvFault, uvStatus, outputEnable}, 3'h7)
    smp(Hi);
    host_u.clear(1'h0);
    repeat (2) @(posedge clk);
    `CHK({uvFault, uvStatus}, 2'h0)
    $display("ignore test done");
  endtask

  task automatic t_latch;
    host_u.wr(iuv_pkg::CmdReaction, 16'h00f8);
    smp(Lo);
    smp(Hi);
    repeat (50) @(posedge clk);
    `CHK(outputEnable, 1'h0)
    host_u.clear(1'h1);
    repeat (3) @(posedge clk);
    `CHK({outputEnable, uvStatus}, 2'h2)
    host_u.wr(iuv_pkg::CmdReaction, 16'h0080);
    smp(Lo);
    repeat (20) @(posedge clk);
    `CHK(outputEnable, 1'h0)
    host_u.clear(1'h1);
    $display("latch test done");
  endtask

  task automatic t_retry;
    unitCycles <= 16'h0002;
    host_u.wr(iuv_pkg::CmdReaction, 16'h0091);
    smp(Lo);
    waitOe(1'h0, n);
    `CHK(n <= 2, 1'h1)
    waitOe(1'h1, n);
    `CHK(n, 4)
    smp(Lo);
    waitOe(1'h0, n);
    waitOe(1'h1, n);
    `CHK(outputEnable, 1'h1)
    smp(Lo);
    repeat (40) @(posedge clk);
    `CHK(outputEnable, 1'h0)
    host_u.clear(1'h1);
    unitCycles <= 16'h0001;
    $display("retry test done");
  endtask

  task automatic t_delayed;
    host_u.wr(iuv_pkg::CmdReaction, 16'h0042);
    smp(Lo);
    smp(Hi);
    repeat (30) @(posedge clk);
    `CHK(outputEnable, 1'h1)
    smp(Lo);
    repeat (2) @(posedge clk);
    `CHK(outputEnable, 1'h1)
    waitOe(1'h0, n);
    `CHK(n, 2)
    repeat (40) @(posedge clk);
    `CHK(outputEnable, 1'h0)
    host_u.clear(1'h1);
    host_u.wr(iuv_pkg::CmdReaction, 16'h0048);
    smp(Lo);
    waitOe(1'h0, n);
    `CHK(n, 1)
    waitOe(1'h1, n);
    `CHK(n, 1)
    smp(Lo);
    repeat (5) @(posedge clk);
    `CHK(outputEnable, 1'h0)
    host_u.clear(1'h1);
    $display("delayed test done");
  endtask

  task automatic t_forever;
    host_u.wr(iuv_pkg::CmdReaction, 16'h00b8);
    for (int i = 0; i < 8; i++) begin
      smp(Lo);
      waitOe(1'h0, n);
      waitOe(1'h1, n);
      `CHK(outputEnable, 1'h1)
    end
    @(posedge clk);
    otherFaultOff <= 1'h1;
    repeat (20) @(posedge clk);
    otherFaultOff <= 1'h0;
    smp(Hi);
    repeat (10) @(posedge clk);
    `CHK(outputEnable, 1'h0)
    runEnable <= 1'h0;
    repeat (3) @(posedge clk);
    runEnable <= 1'h1;
    repeat (3) @(posedge clk);
    `CHK(outputEnable, 1'h1)
    $display("continuous retry test done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_ignore;
    t_latch;
    t_retry;
    t_delayed;
    t_forever;
    final_report;
  end
endmodule
